// File: hdl/sdm_pkg.sv
// constants, tables and carrier types of the standstill delay monitor
// assumes one 20 MHz reference clock and comparator results arriving as raw pins
package sdm_pkg;

    // one delay unit is a millisecond
    localparam int CLK_PERIOD_NS = 50;
    localparam int DELAY_UNIT_NS = 1000000;
    localparam int TICK_CYCLES = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int SEL_W = 4;
    localparam int SEL_POSITIONS = 10;
    localparam int DLY_W = 16;
    localparam int MV_W = 10;
    localparam logic [1:0] CFG_WAIT_DONE = 2'h3;
    localparam logic [DLY_W-1:0] DLY_RESET = 16'h0000;
    localparam logic [MV_W-1:0] MV_RESET = 10'h000;

    // delay in ms: 500 1000 2000 3000 5000 8000 12000 20000 35000 60000
    localparam logic [SEL_POSITIONS-1:0][DLY_W-1:0] DLY_MS_TBL = {
        16'hea60, 16'h88b8, 16'h4e20, 16'h2ee0, 16'h1f40,
        16'h1388, 16'h0bb8, 16'h07d0, 16'h03e8, 16'h01f4};

    // threshold in mV: 50 65 85 110 140 180 230 300 400 500
    localparam logic [SEL_POSITIONS-1:0][MV_W-1:0] THR_MV_TBL = {
        10'h1f4, 10'h190, 10'h12c, 10'h0e6, 10'h0b4,
        10'h08c, 10'h06e, 10'h055, 10'h041, 10'h032};

    typedef enum logic [2:0] {
        ST_HOLD = 3'h1,
        ST_DELAY = 3'h2,
        ST_ACTIVE = 3'h4
    } sdm_state_t;

    // comparator results and broken-wire alert: voltage above threshold, above threshold plus hysteresis
    typedef struct packed {
        logic wire_alert;
        logic above_hyst;
        logic above_thr;
    } sdm_cmp_t;

endpackage

// File: hdl/sdm_standstill_delay_monitor.sv
// decision logic: comparator results in, safety output enable out
// assumes analog side compares against THR_MV and HYST_MV; selectors static after power-up
module sdm_standstill_delay_monitor #(
    parameter int TICK_CYC = sdm_pkg::TICK_CYCLES
)(
    input wire logic REF_CLK, // 20 MHz reference clock
    input wire logic RSTN, // async reset, active low
    input wire sdm_pkg::sdm_cmp_t CMP_IN, // raw comparator and wire-alert pins
    input wire logic [sdm_pkg::SEL_W-1:0] DELAY_SEL, // delay selector position 1..10
    input wire logic [sdm_pkg::SEL_W-1:0] THR_SEL, // threshold selector position 1..10
    output logic OUT_EN, // safety-related outputs energized
    output logic SAFE_STATE, // defined safe state
    output logic DELAY_RUN, // activation delay elapsing
    output logic CFG_FAULT, // selector outside 1..10
    output logic [sdm_pkg::MV_W-1:0] THR_MV, // falling threshold to comparator
    output logic [sdm_pkg::MV_W-1:0] HYST_MV // rising threshold to comparator
);

    localparam int TW = $clog2(TICK_CYC + 1);

    if (TICK_CYC < 1)
    begin : g_chk
        $error("TICK_CYC must be at least 1");
    end

    sdm_pkg::sdm_cmp_t cmp_meta_reg;
    sdm_pkg::sdm_cmp_t cmp_reg;
    logic [sdm_pkg::SEL_W-1:0] dsel_meta_reg, dsel_reg, tsel_meta_reg, tsel_reg;
    logic [1:0] cfg_wait_reg;
    logic cfg_loaded_reg;
    logic cfg_bad_reg;
    logic [sdm_pkg::DLY_W-1:0] dly_ms_reg;
    logic [sdm_pkg::MV_W-1:0] thr_mv_reg;
    logic [TW-1:0] tick_reg, tick_next;
    logic [sdm_pkg::DLY_W-1:0] ms_reg, ms_next;
    sdm_pkg::sdm_state_t state_reg, state_next;
    logic out_en_reg, delay_run_reg;
    logic safe_reg;

    // pins pass two flops; the first stage feeds nothing else
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cmp_meta_reg <= '0;
            cmp_reg <= '0;
            dsel_meta_reg <= '0;
            dsel_reg <= '0;
            tsel_meta_reg <= '0;
            tsel_reg <= '0;
        end
        else
        begin
            cmp_meta_reg <= CMP_IN;
            cmp_reg <= cmp_meta_reg;
            dsel_meta_reg <= DELAY_SEL;
            dsel_reg <= dsel_meta_reg;
            tsel_meta_reg <= THR_SEL;
            tsel_reg <= tsel_meta_reg;
        end
    end

    wire dsel_ok = (dsel_reg >= 4'h1) && (dsel_reg <= 4'ha);
    wire tsel_ok = (tsel_reg >= 4'h1) && (tsel_reg <= 4'ha);
    wire [sdm_pkg::SEL_W-1:0] dsel_idx = dsel_ok ? dsel_reg - 4'h1 : 4'h0;
    wire [sdm_pkg::SEL_W-1:0] tsel_idx = tsel_ok ? tsel_reg - 4'h1 : 4'h0;
    wire cfg_take = !cfg_loaded_reg && (cfg_wait_reg == sdm_pkg::CFG_WAIT_DONE);

    // selectors read once after the sync pipe fills; turning a knob later needs a reset on RSTN
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cfg_wait_reg <= 2'h0;
            cfg_loaded_reg <= 1'b0;
            cfg_bad_reg <= 1'b0;
            dly_ms_reg <= sdm_pkg::DLY_RESET;
            thr_mv_reg <= sdm_pkg::MV_RESET;
        end
        else
        begin
            if (!cfg_loaded_reg)
                cfg_wait_reg <= cfg_wait_reg + 2'h1;
            if (cfg_take)
            begin
                cfg_loaded_reg <= 1'b1;
                cfg_bad_reg <= !(dsel_ok && tsel_ok);
                dly_ms_reg <= sdm_pkg::DLY_MS_TBL[dsel_idx];
                thr_mv_reg <= sdm_pkg::THR_MV_TBL[tsel_idx];
            end
        end
    end

    // anything that forbids leaving the safe state
    wire block_out = !cfg_loaded_reg || cfg_bad_reg || cmp_reg.wire_alert;
    wire tick_end = (tick_reg == TW'(TICK_CYC - 1));
    wire delay_done = tick_end && (ms_reg == dly_ms_reg - 16'h0001);

    always_comb
    begin
        state_next = state_reg;
        tick_next = '0;
        ms_next = '0;
        case (state_reg)
            sdm_pkg::ST_HOLD:
            begin
                if (!cmp_reg.above_thr)
                    state_next = sdm_pkg::ST_DELAY;
            end
            sdm_pkg::ST_DELAY:
            begin
                if (cmp_reg.above_thr)
                    state_next = sdm_pkg::ST_HOLD;
                else if (delay_done)
                    state_next = sdm_pkg::ST_ACTIVE;
                else
                begin
                    tick_next = tick_end ? '0 : tick_reg + TW'(1);
                    ms_next = tick_end ? ms_reg + 16'h0001 : ms_reg;
                end
            end
            sdm_pkg::ST_ACTIVE:
            begin
                // plain threshold crossing alone keeps the outputs on
                if (cmp_reg.above_hyst)
                    state_next = sdm_pkg::ST_HOLD;
            end
            default:
                state_next = sdm_pkg::ST_HOLD;
        endcase
        if (block_out)
        begin
            state_next = sdm_pkg::ST_HOLD;
            tick_next = '0;
            ms_next = '0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_reg <= sdm_pkg::ST_HOLD;
            tick_reg <= '0;
            ms_reg <= sdm_pkg::DLY_RESET;
            out_en_reg <= 1'b0;
            delay_run_reg <= 1'b0;
            safe_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            tick_reg <= tick_next;
            ms_reg <= ms_next;
            out_en_reg <= (state_next == sdm_pkg::ST_ACTIVE);
            delay_run_reg <= (state_next == sdm_pkg::ST_DELAY);
            // own flop so the safe-state pin has no gate behind it
            safe_reg <= (state_next != sdm_pkg::ST_ACTIVE);
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            THR_MV <= sdm_pkg::MV_RESET;
            HYST_MV <= sdm_pkg::MV_RESET;
            CFG_FAULT <= 1'b0;
        end
        else
        begin
            THR_MV <= thr_mv_reg;
            // top bit dropped: the largest threshold doubled still fits
            HYST_MV <= {thr_mv_reg[sdm_pkg::MV_W-2:0], 1'b0};
            CFG_FAULT <= cfg_bad_reg;
        end
    end

    assign OUT_EN = out_en_reg;
    assign SAFE_STATE = safe_reg;
    assign DELAY_RUN = delay_run_reg;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    stop_detect_a: assert property (
        state_reg == sdm_pkg::ST_HOLD && !cmp_reg.above_thr && !block_out
        |=> DELAY_RUN && ms_reg == 16'h0000)
        else $error("fall below threshold did not start delay");
    move_hyst_a: assert property (
        OUT_EN && cmp_reg.above_hyst |=> !OUT_EN ##1 HYST_MV == 2 * THR_MV)
        else $error("hysteresis crossing mishandled");
    fall_plain_a: assert property (
        DELAY_RUN && !cmp_reg.above_thr && !block_out && !delay_done
        |=> DELAY_RUN)
        else $error("delay interrupted without threshold crossing");
    delay_safe_a: assert property (
        DELAY_RUN |-> SAFE_STATE && !OUT_EN)
        else $error("outputs on during delay");
    safe_pair_a: assert property (
        SAFE_STATE == !OUT_EN)
        else $error("safe state and outputs disagree");
    full_delay_a: assert property (
        $rose(OUT_EN) |-> $past(delay_done) && $past(ms_reg) == dly_ms_reg - 16'h0001)
        else $error("outputs on before delay expired");
    restart_zero_a: assert property (
        DELAY_RUN && cmp_reg.above_thr |=> !OUT_EN && !DELAY_RUN && ms_reg == 16'h0000)
        else $error("rise during delay not handled");
    energize_a: assert property (
        DELAY_RUN && delay_done && !cmp_reg.above_thr && !block_out |=> OUT_EN)
        else $error("outputs not energized after delay");
    hold_band_a: assert property (
        OUT_EN && !cmp_reg.above_hyst && !block_out |=> OUT_EN)
        else $error("outputs dropped inside band");
    drop_out_a: assert property (
        OUT_EN && cmp_reg.above_hyst |=> SAFE_STATE)
        else $error("outputs not dropped above hysteresis");
    alert_safe_a: assert property (
        cmp_reg.wire_alert |=> !OUT_EN && !DELAY_RUN)
        else $error("wire alert did not force safe state");
    alert_clear_a: assert property (
        $fell(cmp_reg.wire_alert) && cfg_loaded_reg && !cfg_bad_reg && !cmp_reg.above_thr
        |=> DELAY_RUN)
        else $error("cleared alert did not allow delay start");
    cfg_frozen_a: assert property (
        cfg_loaded_reg |=> $stable(dly_ms_reg) && $stable(thr_mv_reg) && cfg_loaded_reg)
        else $error("latched configuration changed");

    cov_energize_c: cover property ($rose(OUT_EN));
    cov_restart_c: cover property (DELAY_RUN && cmp_reg.above_thr);
    cov_band_c: cover property (OUT_EN && cmp_reg.above_thr && !cmp_reg.above_hyst ##1 OUT_EN);
    cov_alert_c: cover property (OUT_EN ##1 cmp_reg.wire_alert);

endmodule

// File: dv/sdm_cmp_model.sv
// comparator model: residual voltage against the two levels the block selects
// assumes the bench sets the voltage in mV and the broken-wire flag
module sdm_cmp_model (
    input wire logic [sdm_pkg::MV_W:0] volt_mv, // measured voltage
    input wire logic wire_brk, // broken wire seen
    input wire logic [sdm_pkg::MV_W-1:0] thr_mv, // falling threshold
    input wire logic [sdm_pkg::MV_W-1:0] hyst_mv, // rising threshold
    output sdm_pkg::sdm_cmp_t cmp // comparator pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // strict compare: a voltage equal to a level reads as below it
    // one driver for the whole struct: wire_alert, above_hyst, above_thr
    assign cmp = {wire_brk,
        volt_mv > {1'b0, hyst_mv},
        volt_mv > {1'b0, thr_mv}};
endmodule

// File: dv/test_standstill_delay_monitor.sv
// self-checking bench: selectors per row, voltage through the comparator model
// assumes TICK_CYC of 1, so one table millisecond is one clock
module test_standstill_delay_monitor;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [3:0] sel; int thr; int dly;} sdm_row_t;
    localparam int TICK = 1;
    localparam int LIMIT = 97000;
    sdm_row_t rows [10] = '{'{4'h1, 50, 500}, '{4'h2, 65, 1000}, '{4'h3, 85, 2000},
        '{4'h4, 110, 3000}, '{4'h5, 140, 5000}, '{4'h6, 180, 8000}, '{4'h7, 230, 12000},
        '{4'h8, 300, 20000}, '{4'h9, 400, 35000}, '{4'ha, 500, 60000}};
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic brk = 1'b0;
    logic [sdm_pkg::MV_W:0] volt = 11'h3ff;
    logic [3:0] dsel = 4'h1;
    logic [3:0] tsel = 4'h1;
    sdm_pkg::sdm_cmp_t cmp;
    logic out_en, safe, drun, cfg_f;
    logic [sdm_pkg::MV_W-1:0] thr, hyst;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int n;

    always #25 ref_clk = ~ref_clk;

    sdm_cmp_model i_sdm_cmp_model (.volt_mv(volt), .wire_brk(brk), .thr_mv(thr),
        .hyst_mv(hyst), .cmp(cmp));
    sdm_standstill_delay_monitor #(.TICK_CYC(TICK)) i_sdm_standstill_delay_monitor (
        .REF_CLK(ref_clk), .RSTN(rstn), .CMP_IN(cmp), .DELAY_SEL(dsel), .THR_SEL(tsel),
        .OUT_EN(out_en), .SAFE_STATE(safe), .DELAY_RUN(drun), .CFG_FAULT(cfg_f),
        .THR_MV(thr), .HYST_MV(hyst));

    task automatic chk_val(logic [31:0] got, logic [31:0] exp, string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic step(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic set_v(int v, logic b);
        @(posedge ref_clk);
        volt <= 11'(v);
        brk <= b;
    endtask

    task automatic do_reset(logic [3:0] d, logic [3:0] t);
        @(posedge ref_clk);
        rstn <= 1'b0;
        dsel <= d;
        tsel <= t;
        volt <= 11'h3ff;
        brk <= 1'b0;
        step(9);
        chk_val(safe, 1'b1, "safe in reset");
        chk_val(out_en, 1'b0, "outputs in reset");
        @(posedge ref_clk);
        rstn <= 1'b1;
        step(6);
    endtask

    // cycles from delay start to outputs energized
    task automatic run_delay(output int k);
        k = 0;
        set_v(0, 1'b0);
        while (drun !== 1'b1 && k < 8)
        begin
            step(1);
            k++;
        end
        chk_val(out_en, 1'b0, "off at delay start");
        k = 0;
        while (out_en !== 1'b1 && k < 70000)
        begin
            step(1);
            k++;
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            complete_run;
        end
    end

    initial
    begin
        foreach (rows[i])
        begin
            do_reset(rows[i].sel, rows[i].sel);
            chk_val(thr, rows[i].thr, "threshold map");
            chk_val(hyst, 2 * rows[i].thr, "hysteresis level");
            chk_val(cfg_f, 1'b0, "config fault");
            // longest delay left out: its 60000 cycles would push the run past LIMIT
            if (rows[i].dly < 60000)
            begin
                run_delay(n);
                chk_val(n, rows[i].dly * TICK, "delay length");
                chk_val(safe, 1'b0, "safe state left");
            end
            $display("row %0d done", i + 1);
        end
        do_reset(4'h1, 4'h1);
        set_v(0, 1'b0);
        step(100);
        chk_val({drun, out_en}, 2'h2, "delay running, off");
        set_v(60, 1'b0);
        step(4);
        chk_val({drun, out_en}, 2'h0, "delay cleared, off");
        run_delay(n);
        chk_val(n, 500 * TICK, "full restart");
        $display("interrupted delay done");
        set_v(100, 1'b0);
        step(20);
        chk_val(out_en, 1'b1, "held in band");
        set_v(101, 1'b0);
        step(4);
        chk_val(out_en, 1'b0, "dropped above band");
        $display("hysteresis done");
        run_delay(n);
        set_v(0, 1'b1);
        step(4);
        chk_val(out_en, 1'b0, "alert forces safe");
        step(600);
        chk_val(out_en, 1'b0, "alert holds safe");
        set_v(200, 1'b0);
        step(600);
        chk_val(out_en, 1'b0, "clear alert above threshold");
        run_delay(n);
        chk_val(n, 500 * TICK, "delay after alert");
        set_v(0, 1'b1);
        step(10);
        set_v(0, 1'b0);
        step(4);
        chk_val({drun, out_en}, 2'h2, "alert gone below threshold");
        $display("broken wire done");
        do_reset(4'h0, 4'h1);
        chk_val(cfg_f, 1'b1, "bad selector");
        set_v(0, 1'b0);
        step(600);
        chk_val(out_en, 1'b0, "fault keeps safe");
        $display("selector fault done");
        complete_run;
    end
endmodule
